// ### verilog/itc_ctrl.sv
// interrupt global control, trap cause flags and first request flags
//
// Overview of operation
// - nesting off stops any interrupt preempting a handler in service
// - bits 14 and 13 flag an enabled ordinary overflow trap of A or B
// - bits 12 and 11 flag catastrophic overflow trap of A or B
// - bits 10 and 9 enable ordinary overflow traps of A and B
// - bit 8 enables catastrophic overflow traps of either accumulator
// - bit 7 flags a math trap from an invalid accumulator shift
// - bit 6 flags a math trap from division by zero
// - bit 5 flags a dma controller error trap
// - bit 4 flags any math error trap whatever the cause
// - bit 3 flags an address error trap
// - bit 2 flags a stack error trap; bit 0 reads zero
// - bit 1 flags an oscillator failure trap; bit 0 reads zero
// - control two bit 15 selects the alternate vector table
// - control two bit 14 reads one while interrupt hold is active
// - control two bits 13 to 5 always read zero
// - control two bits 4 to 0 pick edge polarity, one is falling
// - request flag reads one once its source asked; bit 15 is zero
// - flag bits 14 to 0 map dma1 down to external line zero
// - flags are set by sources and cleared only by software writes
// - cpu priority level is read-only while nesting is off
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module itc_ctrl
  import itc_pkg::*;
#(
  parameter int NEXT = EXT_N
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // register port
  input  wire logic [AW-1:0]   reg_addr,
  input  wire logic [DW-1:0]   reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [DW-1:0]   reg_rdata_q,
  // cpu core status and priority load
  input  wire logic            handler_busy,
  input  wire logic            irq_hold_active,
  input  wire logic            ipl_load,
  input  wire logic [IPL_W-1:0] ipl_load_val,
  // arithmetic and system trap events, one-cycle pulses
  input  wire logic            acc_a_ovf,
  input  wire logic            acc_b_ovf,
  input  wire logic            acc_a_cat_ovf,
  input  wire logic            acc_b_cat_ovf,
  input  wire logic            bad_shift,
  input  wire logic            divide_zero,
  input  wire logic            dma_fault,
  input  wire logic            addr_fault,
  input  wire logic            stack_fault,
  input  wire logic            osc_fault,
  // peripheral request pulses
  input  wire logic            dma1_req,
  input  wire logic            adc1_req,
  input  wire logic            uart1_tx_req,
  input  wire logic            uart1_rx_req,
  input  wire logic            spi1_evt_req,
  input  wire logic            spi1_fault_req,
  input  wire logic            tmr3_req,
  input  wire logic            tmr2_req,
  input  wire logic            cmp2_req,
  input  wire logic            cap2_req,
  input  wire logic            dma0_req,
  input  wire logic            tmr1_req,
  input  wire logic            cmp1_req,
  input  wire logic            cap1_req,
  // external interrupt lines
  input  wire logic [NEXT-1:0] ext_pin,
  // outputs toward the core and the priority logic
  output logic                 preempt_ok_q,
  output logic                 math_trap_q,
  output logic                 alt_table_sel,
  output logic      [IPL_W-1:0] cpu_priority_level,
  output logic      [DW-1:0]   request_flags,
  output logic      [DW-1:0]   trap_flags,
  output logic      [NEXT-1:1] ext_edge_q
);
  // access decode
  itc_acc_e acc;
  logic     wr_one, wr_two, wr_flags, wr_lvl;

  // control state
  logic             nesting_off, nesting_off_d;
  logic [2:0]       trap_en_q, trap_en_d;
  logic             alt_table_d;
  logic [NEXT-1:0]  ext_polarity, ext_polarity_d;
  logic [IPL_W-1:0] ipl_d;

  // derived events and read path
  logic [NEXT-1:0]  edge_hit;
  logic [DW-1:0]    trap_set, req_set, rd_val, rdata_d;
  logic             a_ovf_trap, b_ovf_trap, a_cat_trap, b_cat_trap;
  logic             any_math, preempt_d, math_trap_d;
  logic [NEXT-1:1]  ext_edge_d;

  // strobes are never both high, so the decode is a plain choice
  always_comb begin
    if (reg_wr) begin
      acc = ITC_ACC_WRITE;
    end else if (reg_rd) begin
      acc = ITC_ACC_READ;
    end else begin
      acc = ITC_ACC_IDLE;
    end
  end

  assign wr_one   = (acc == ITC_ACC_WRITE) && (reg_addr == OFS_CTRL_ONE);
  assign wr_two   = (acc == ITC_ACC_WRITE) && (reg_addr == OFS_CTRL_TWO);
  assign wr_flags = (acc == ITC_ACC_WRITE) && (reg_addr == OFS_FLAGS_ZERO);
  assign wr_lvl   = (acc == ITC_ACC_WRITE) && (reg_addr == OFS_CPU_LEVEL);

  // overflow traps only count when enabled; the others always trap
  always_comb begin
    a_ovf_trap = acc_a_ovf & trap_en_q[2];
    b_ovf_trap = acc_b_ovf & trap_en_q[1];
    a_cat_trap = acc_a_cat_ovf & trap_en_q[0];
    b_cat_trap = acc_b_cat_ovf & trap_en_q[0];
    any_math   = a_ovf_trap | b_ovf_trap | a_cat_trap | b_cat_trap
               | bad_shift | divide_zero;
    trap_set          = RST_WORD;
    trap_set[B_A_OVF] = a_ovf_trap;
    trap_set[B_B_OVF] = b_ovf_trap;
    trap_set[B_A_CAT] = a_cat_trap;
    trap_set[B_B_CAT] = b_cat_trap;
    trap_set[B_SHIFT] = bad_shift;
    trap_set[B_DIV0]  = divide_zero;
    trap_set[B_DMA]   = dma_fault;
    trap_set[B_MATH]  = any_math;
    trap_set[B_ADDR]  = addr_fault;
    trap_set[B_STACK] = stack_fault;
    trap_set[B_OSC]   = osc_fault;
  end

  // trap cause flags sit in the implemented flag bits of control one
  itc_flag_bank #(
    .W    (DW),
    .MASK (ONE_FLAG_MASK)
  ) u_trap_flags (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (trap_set),
    .wr_en   (wr_one),
    .wr_data (reg_wdata),
    .flags_q (trap_flags)
  );

  // external lines: two-flop sync then polarity-selected edge
  itc_edge_det #(
    .N (NEXT)
  ) u_edge (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin      (ext_pin),
    .pol      (ext_polarity),
    .edge_hit (edge_hit)
  );

  // request sources in flag order, bit 14 down to bit 0
  assign req_set = {1'b0, dma1_req, adc1_req, uart1_tx_req, uart1_rx_req,
                    spi1_evt_req, spi1_fault_req, tmr3_req, tmr2_req,
                    cmp2_req, cap2_req, dma0_req, tmr1_req, cmp1_req,
                    cap1_req, edge_hit[B_EXT0]};

  // bit 15 is masked off so it can never read one
  itc_flag_bank #(
    .W    (DW),
    .MASK (FLAGS_MASK)
  ) u_req_flags (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set     (req_set),
    .wr_en   (wr_flags),
    .wr_data (reg_wdata),
    .flags_q (request_flags)
  );

  // control registers: nesting, enables, table select, polarity, level
  always_comb begin
    nesting_off_d  = nesting_off;
    trap_en_d      = trap_en_q;
    alt_table_d    = alt_table_sel;
    ext_polarity_d = ext_polarity;
    ipl_d          = cpu_priority_level;
    if (wr_one) begin
      nesting_off_d = reg_wdata[B_NEST];
      trap_en_d     = {reg_wdata[B_A_TE], reg_wdata[B_B_TE],
                       reg_wdata[B_CAT_TE]};
    end
    if (wr_two) begin
      alt_table_d    = reg_wdata[B_ALT];
      ext_polarity_d = reg_wdata[NEXT-1:0];
    end
    // the core's own level load outranks software
    if (ipl_load) begin
      ipl_d = ipl_load_val;
    end else if (wr_lvl && !nesting_off) begin
      ipl_d = reg_wdata[IPL_W-1:0];
    end
  end

  // nesting off: a busy handler cannot be preempted
  always_comb begin
    preempt_d   = !(nesting_off && handler_busy);
    math_trap_d = any_math;
    ext_edge_d  = edge_hit[NEXT-1:1];
  end

  // read mux; unmapped offsets and unimplemented bits read zero
  always_comb begin
    rd_val = RST_WORD;
    unique case (reg_addr)
      OFS_CTRL_ONE: begin
        rd_val           = trap_flags & ONE_FLAG_MASK;
        rd_val[B_NEST]   = nesting_off;
        rd_val[B_A_TE]   = trap_en_q[2];
        rd_val[B_B_TE]   = trap_en_q[1];
        rd_val[B_CAT_TE] = trap_en_q[0];
      end
      OFS_CTRL_TWO: begin
        rd_val[B_ALT]      = alt_table_sel;
        rd_val[B_HOLD]     = irq_hold_active;
        rd_val[NEXT-1:0]   = ext_polarity;
      end
      OFS_FLAGS_ZERO: begin
        rd_val = request_flags;
      end
      OFS_CPU_LEVEL: begin
        rd_val[IPL_W-1:0] = cpu_priority_level;
      end
      default: begin
        rd_val = RST_WORD;
      end
    endcase
    // read data stands only in the cycle after the read strobe
    rdata_d = (acc == ITC_ACC_READ) ? rd_val : RST_WORD;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nesting_off        <= 1'b0;
      trap_en_q          <= RST_TE;
      alt_table_sel      <= 1'b0;
      ext_polarity       <= RST_POL[NEXT-1:0];
      cpu_priority_level <= RST_IPL;
      preempt_ok_q       <= 1'b1;
      math_trap_q        <= 1'b0;
      ext_edge_q         <= '0;
      reg_rdata_q        <= RST_WORD;
    end else begin
      nesting_off        <= nesting_off_d;
      trap_en_q          <= trap_en_d;
      alt_table_sel      <= alt_table_d;
      ext_polarity       <= ext_polarity_d;
      cpu_priority_level <= ipl_d;
      preempt_ok_q       <= preempt_d;
      math_trap_q        <= math_trap_d;
      ext_edge_q         <= ext_edge_d;
      reg_rdata_q        <= rdata_d;
    end
  end

  // checks on the design's own outputs
  AST_NEST_BLOCK: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (nesting_off && handler_busy) |=> !preempt_ok_q)
    else $error("preemption allowed while nesting is off");

  AST_A_OVF_FLAG: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (acc_a_ovf && trap_en_q[2]) |=> (trap_flags[B_A_OVF] && math_trap_q))
    else $error("enabled overflow of A did not flag a trap");

  AST_B_CAT_FLAG: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (acc_b_cat_ovf && trap_en_q[0]) |=> trap_flags[B_B_CAT])
    else $error("catastrophic overflow of B not flagged");

  AST_OVF_SUPPRESS: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (acc_a_ovf && !trap_en_q[2] && !acc_b_ovf && !acc_a_cat_ovf
     && !acc_b_cat_ovf && !bad_shift && !divide_zero) |=> !math_trap_q)
    else $error("disabled overflow still raised a math trap");

  AST_DIV_MATH: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    divide_zero |=> (trap_flags[B_DIV0] && trap_flags[B_MATH]))
    else $error("divide by zero did not set both flags");

  AST_ONE_BIT0: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_CTRL_ONE) |=> !reg_rdata_q[0])
    else $error("control one bit 0 read as one");

  AST_ALT_WRITE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_two |=> (alt_table_sel == $past(reg_wdata[B_ALT])))
    else $error("table select did not follow the write");

  AST_TWO_READ: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_CTRL_TWO) |=>
      (reg_rdata_q[13:5] == 9'h000
       && reg_rdata_q[B_HOLD] == $past(irq_hold_active)))
    else $error("control two read wrong hold or reserved bits");

  AST_REQ_SET: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (|req_set) |=> (((request_flags & $past(req_set)) == $past(req_set))
                    && !request_flags[15]))
    else $error("request did not set its flag");

  AST_EXT0_EDGE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ($rose(ext_pin[0]) && !ext_polarity[0]) ##1
      (ext_pin[0] && !ext_polarity[0]) |-> ##2 request_flags[0])
    else $error("rising edge on line zero did not set its flag");

  AST_IPL_LOCK: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_lvl && nesting_off && !ipl_load) |=> $stable(cpu_priority_level))
    else $error("priority level changed while locked");

  AST_SHIFT_FLAG: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    bad_shift |=> (trap_flags[B_SHIFT] && trap_flags[B_MATH] && math_trap_q))
    else $error("invalid shift did not flag a math trap");

  AST_DMA_FLAG: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dma_fault |=> trap_flags[B_DMA])
    else $error("dma controller error not flagged");

  AST_STACK_FLAG: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    stack_fault |=> (trap_flags[B_STACK] && !trap_flags[0]))
    else $error("stack error not flagged or bit 0 set");

  // a flag may only fall in the cycle after a software write
  AST_REQ_HOLD: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !wr_flags |=> ((request_flags & $past(request_flags))
                   == $past(request_flags)))
    else $error("request flag dropped without a software write");
endmodule : itc_ctrl

// ### include/itc_pkg.sv
// shared constants for the interrupt trap and control flag block
package itc_pkg;
  // bus geometry
  localparam int          DW             = 16;
  localparam int          AW             = 4;
  localparam int          EXT_N          = 5;
  localparam int          IPL_W          = 3;

  // register byte offsets
  localparam logic [3:0]  OFS_CTRL_ONE   = 4'h0;
  localparam logic [3:0]  OFS_CTRL_TWO   = 4'h2;
  localparam logic [3:0]  OFS_FLAGS_ZERO = 4'h4;
  localparam logic [3:0]  OFS_CPU_LEVEL  = 4'h6;

  // control one field positions
  localparam int          B_NEST         = 15;
  localparam int          B_A_OVF        = 14;
  localparam int          B_B_OVF        = 13;
  localparam int          B_A_CAT        = 12;
  localparam int          B_B_CAT        = 11;
  localparam int          B_A_TE         = 10;
  localparam int          B_B_TE         = 9;
  localparam int          B_CAT_TE       = 8;
  localparam int          B_SHIFT        = 7;
  localparam int          B_DIV0         = 6;
  localparam int          B_DMA          = 5;
  localparam int          B_MATH         = 4;
  localparam int          B_ADDR         = 3;
  localparam int          B_STACK        = 2;
  localparam int          B_OSC          = 1;

  // control two field positions
  localparam int          B_ALT          = 15;
  localparam int          B_HOLD         = 14;
  localparam int          B_EXT0         = 0;

  // implemented bit masks
  localparam logic [15:0] ONE_FLAG_MASK  = 16'h78FE;
  localparam logic [15:0] TWO_POL_MASK   = 16'h001F;
  localparam logic [15:0] FLAGS_MASK     = 16'h7FFF;

  // reset values
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic [2:0]  RST_TE         = 3'h0;
  localparam logic [4:0]  RST_POL        = 5'h00;
  localparam logic [2:0]  RST_IPL        = 3'h0;

  // bus access kind decoded each cycle
  typedef enum logic [1:0] {
    ITC_ACC_IDLE  = 2'b00,
    ITC_ACC_WRITE = 2'b01,
    ITC_ACC_READ  = 2'b10
  } itc_acc_e;
endpackage : itc_pkg

// ### verilog/itc_edge_det.sv
// synchroniser and polarity-selected edge detector for external lines
`timescale 1ns/1ps
module itc_edge_det #(
  parameter int N = 5
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // lines and polarity, one selects falling edges
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] pol,
  // one-cycle edge strobes
  output logic      [N-1:0] edge_hit
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;
      // next values; meta_q feeds only the second stage
      always_comb begin
        meta_d = pin[g];
        sync_d = meta_q;
        prev_d = sync_q;
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          sync_q <= sync_d;
          prev_q <= prev_d;
        end
      end
      // falling edge when polarity set, rising when clear
      assign edge_hit[g] = pol[g] ? (prev_q & ~sync_q)
                                  : (~prev_q & sync_q);
    end
  endgenerate
endmodule : itc_edge_det

// ### verilog/itc_flag_bank.sv
// bank of sticky flags, set by hardware and written by software
`timescale 1ns/1ps
module itc_flag_bank #(
  parameter int          W    = 16,
  parameter logic [15:0] MASK = 16'hFFFF
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // hardware set strobes and software write
  input  wire logic [W-1:0] set,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  // flag state
  output logic      [W-1:0] flags_q
);
  logic [W-1:0] flags_d;

  // a set in the same cycle as a clearing write wins
  always_comb begin
    flags_d = ((wr_en ? wr_data : flags_q) | set) & MASK[W-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule : itc_flag_bank

// ### tb/itc_far_model.sv
// behavioural model of the core, peripherals and external lines
`timescale 1ns/1ps
module itc_far_model
  import itc_pkg::*;
(
  // clock
  input  wire logic             clk_sys,
  // core status and priority load
  output logic                  handler_busy,
  output logic                  irq_hold_active,
  output logic                  ipl_load,
  output logic      [IPL_W-1:0] ipl_load_val,
  // trap events and peripheral requests, one-cycle pulses
  output logic      [9:0]       trap_ev,
  output logic      [13:0]      per_req,
  // external lines
  output logic      [EXT_N-1:0] ext_pin
);
  // idle levels from time zero, lines start low like the reset stages
  initial begin
    handler_busy    = 1'b0;
    irq_hold_active = 1'b0;
    ipl_load        = 1'b0;
    ipl_load_val    = 3'h0;
    trap_ev         = 10'h000;
    per_req         = 14'h0000;
    ext_pin         = 5'h00;
  end

  // one-cycle trap pulse; bit 9 is accumulator a ordinary overflow
  task automatic fire_trap(input int i);
    @(posedge clk_sys);
    trap_ev[i] <= 1'b1;
    @(posedge clk_sys);
    trap_ev[i] <= 1'b0;
  endtask : fire_trap

  // a peripheral only ever sets its flag, never clears it
  task automatic fire_req(input int i);
    @(posedge clk_sys);
    per_req[i] <= 1'b1;
    @(posedge clk_sys);
    per_req[i] <= 1'b0;
  endtask : fire_req

  // core loads a new priority level for one cycle
  task automatic load_level(input logic [IPL_W-1:0] v);
    @(posedge clk_sys);
    ipl_load     <= 1'b1;
    ipl_load_val <= v;
    @(posedge clk_sys);
    ipl_load     <= 1'b0;
    ipl_load_val <= ~v;
  endtask : load_level

  // core status levels
  task automatic set_core(input logic busy, input logic hold);
    @(posedge clk_sys);
    handler_busy    <= busy;
    irq_hold_active <= hold;
  endtask : set_core

  // external line level, changed right after an edge
  task automatic set_line(input int i, input logic v);
    @(posedge clk_sys);
    ext_pin[i] <= v;
  endtask : set_line
endmodule : itc_far_model

// ### tb/testbench.sv
// self-checking bench for the interrupt trap and control flag block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import itc_pkg::*;
;
  logic             clk_sys;
  logic             rst_n;
  logic [AW-1:0]    reg_addr;
  logic [DW-1:0]    reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [DW-1:0]    reg_rdata_q;
  logic             handler_busy;
  logic             irq_hold_active;
  logic             ipl_load;
  logic [IPL_W-1:0] ipl_load_val;
  logic [9:0]       trap_ev;
  logic [13:0]      per_req;
  logic [EXT_N-1:0] ext_pin;
  logic             preempt_ok_q;
  logic             math_trap_q;
  logic             alt_table_sel;
  logic [IPL_W-1:0] cpu_priority_level;
  logic [DW-1:0]    request_flags;
  logic [DW-1:0]    trap_flags;
  logic [EXT_N-1:1] ext_edge_q;
  int               fail_count = 0;
  int               n_tests = 0;
  // expected control one flags per trap index, osc fault first
  logic [15:0] exp_tab [10] = '{16'h0002, 16'h0004, 16'h0008, 16'h0020,
    16'h0050, 16'h0090, 16'h0810, 16'h1010, 16'h2010, 16'h4010};

  // free-running system clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  itc_far_model u_far (
    .clk_sys(clk_sys), .handler_busy(handler_busy),
    .irq_hold_active(irq_hold_active), .ipl_load(ipl_load),
    .ipl_load_val(ipl_load_val), .trap_ev(trap_ev), .per_req(per_req),
    .ext_pin(ext_pin));

  itc_ctrl dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .handler_busy(handler_busy),
    .irq_hold_active(irq_hold_active), .ipl_load(ipl_load),
    .ipl_load_val(ipl_load_val), .acc_a_ovf(trap_ev[9]),
    .acc_b_ovf(trap_ev[8]), .acc_a_cat_ovf(trap_ev[7]),
    .acc_b_cat_ovf(trap_ev[6]), .bad_shift(trap_ev[5]),
    .divide_zero(trap_ev[4]), .dma_fault(trap_ev[3]),
    .addr_fault(trap_ev[2]), .stack_fault(trap_ev[1]),
    .osc_fault(trap_ev[0]), .dma1_req(per_req[13]),
    .adc1_req(per_req[12]), .uart1_tx_req(per_req[11]),
    .uart1_rx_req(per_req[10]), .spi1_evt_req(per_req[9]),
    .spi1_fault_req(per_req[8]), .tmr3_req(per_req[7]),
    .tmr2_req(per_req[6]), .cmp2_req(per_req[5]), .cap2_req(per_req[4]),
    .dma0_req(per_req[3]), .tmr1_req(per_req[2]), .cmp1_req(per_req[1]),
    .cap1_req(per_req[0]), .ext_pin(ext_pin),
    .preempt_ok_q(preempt_ok_q), .math_trap_q(math_trap_q),
    .alt_table_sel(alt_table_sel), .cpu_priority_level(cpu_priority_level),
    .request_flags(request_flags), .trap_flags(trap_flags),
    .ext_edge_q(ext_edge_q));

  // one-cycle write strobe
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata_q;
  endtask : reg_read

  // count edge pulses of one line over a fixed span
  task automatic count_edge(input int i, output int n);
    n = 0;
    repeat (6) begin
      @(posedge clk_sys);
      #1 if (ext_edge_q[i] !== 1'b0) n++;
    end
  endtask : count_edge

  task automatic t_reset();
    logic [15:0] rd;
    `CHK(preempt_ok_q, 1'b1)
    reg_write(4'hA, 16'hFFFF); // unmapped write must be ignored
    for (int a = 0; a <= 10; a += 2) begin
      reg_read(a[3:0], rd);
      `CHK(rd, 16'h0000)
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_ctrl_two();
    logic [15:0] rd;
    u_far.set_core(1'b0, 1'b1);
    reg_write(OFS_CTRL_TWO, 16'hFFFF);
    reg_read(OFS_CTRL_TWO, rd);
    `CHK(rd, 16'hC01F)
    `CHK(alt_table_sel, 1'b1)
    u_far.set_core(1'b0, 1'b0);
    reg_write(OFS_CTRL_TWO, 16'h0000);
    reg_read(OFS_CTRL_TWO, rd);
    `CHK(rd, 16'h0000)
    `CHK(alt_table_sel, 1'b0)
    $display("test ctrl_two done");
  endtask : t_ctrl_two

  task automatic t_traps();
    logic [15:0] rd;
    reg_write(OFS_CTRL_ONE, 16'h0000);
    u_far.fire_trap(9);
    u_far.fire_trap(6);
    reg_read(OFS_CTRL_ONE, rd);
    `CHK(rd, 16'h0000)
    reg_write(OFS_CTRL_ONE, 16'h0700);
    for (int i = 0; i < 10; i++) begin
      u_far.fire_trap(i);
      #1 `CHK(math_trap_q, exp_tab[i][B_MATH])
      `CHK(trap_flags, exp_tab[i])
      reg_read(OFS_CTRL_ONE, rd);
      `CHK(rd, exp_tab[i] | 16'h0700)
      reg_write(OFS_CTRL_ONE, 16'h0700);
    end
    $display("test traps done");
  endtask : t_traps

  task automatic t_flags();
    logic [15:0] rd;
    for (int i = 0; i < 14; i++) begin
      u_far.fire_req(i);
      repeat (3) @(posedge clk_sys);
      #1 `CHK(request_flags, 16'h0002 << i)
      reg_write(OFS_FLAGS_ZERO, 16'h0000);
      #1 `CHK(request_flags, 16'h0000)
    end
    // a request landing with a clearing write must survive it
    fork
      u_far.fire_req(0);
      reg_write(OFS_FLAGS_ZERO, 16'h0000);
    join
    #1 `CHK(request_flags, 16'h0002)
    reg_write(OFS_FLAGS_ZERO, 16'h0000);
    reg_write(OFS_FLAGS_ZERO, 16'hFFFF);
    reg_read(OFS_FLAGS_ZERO, rd);
    `CHK(rd, 16'h7FFF)
    reg_write(OFS_FLAGS_ZERO, 16'h0000);
    $display("test flags done");
  endtask : t_flags

  task automatic t_ext();
    int n;
    u_far.set_line(0, 1'b1);
    repeat (4) @(posedge clk_sys);
    #1 `CHK(request_flags[0], 1'b1)
    reg_write(OFS_FLAGS_ZERO, 16'h0000);
    u_far.set_line(0, 1'b0);
    repeat (4) @(posedge clk_sys);
    #1 `CHK(request_flags[0], 1'b0)
    reg_write(OFS_CTRL_TWO, 16'h001E);
    for (int i = 1; i < EXT_N; i++) begin
      u_far.set_line(i, 1'b1);
      count_edge(i, n);
      `CHK(n, 0)
      u_far.set_line(i, 1'b0);
      count_edge(i, n);
      `CHK(n, 1)
    end
    reg_write(OFS_CTRL_TWO, 16'h0000);
    $display("test ext done");
  endtask : t_ext

  task automatic t_nest();
    logic [15:0] rd;
    u_far.set_core(1'b1, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(preempt_ok_q, 1'b1)
    reg_write(OFS_CTRL_ONE, 16'h8000);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(preempt_ok_q, 1'b0)
    reg_write(OFS_CPU_LEVEL, 16'h0005);
    reg_read(OFS_CPU_LEVEL, rd);
    `CHK(rd, 16'h0000)
    u_far.load_level(3'h3);
    #1 `CHK(cpu_priority_level, 3'h3)
    reg_write(OFS_CTRL_ONE, 16'h0000);
    reg_write(OFS_CPU_LEVEL, 16'h0005);
    #1 `CHK(cpu_priority_level, 3'h5)
    u_far.set_core(1'b0, 1'b0);
    $display("test nest done");
  endtask : t_nest

  // single closing point for both normal end and watchdog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    rst_n     = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_ctrl_two();
    t_traps();
    t_flags();
    t_ext();
    t_nest();
    print_verdict();
  end

  // watchdog, the tests take well under 2000 cycles
  initial begin
    #50000;
    fail_count++;
    print_verdict();
  end
endmodule : testbench
